// file: core/fcoi_pkg.sv
// Package for the flash command object interface: map, fields, types.
package fcoi_pkg;
  // Register byte offsets on the bus
  localparam logic [7:0] OFS_INDEX = 8'h00;
  localparam logic [7:0] OFS_WORD = 8'h04;
  localparam logic [7:0] OFS_STATUS = 8'h08;
  localparam logic [7:0] OFS_CLKDIV = 8'h0C;
  localparam logic [7:0] OFS_PROT_SIZE = 8'h10;
  localparam logic [7:0] OFS_PROT_END = 8'h14;
  localparam logic [7:0] OFS_RSV_ZERO = 8'h18;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h1C;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h20;
  // Status register field positions
  localparam int unsigned COMMAND_COMPLETE_FLAG_POS = 7;
  localparam int unsigned ACCESS_ERROR_FLAG_POS = 5;
  localparam int unsigned PROTECTION_VIOLATION_FLAG_POS = 4;
  // Clock divider fields
  localparam int unsigned DIV_LOADED_POS = 7;
  localparam int unsigned DIV_W = 7;
  // Interrupt status bits
  localparam int unsigned IRQ_DONE_POS = 0;
  localparam int unsigned IRQ_ACCESS_ERROR_FLAG_POS = 1;
  localparam int unsigned IRQ_PVIOL_POS = 2;
  localparam int unsigned IRQ_W = 3;
  // Command object geometry
  localparam int unsigned COB_WORDS = 6;
  localparam int unsigned IDX_W = 3;
  // Protection decode
  localparam logic [22:0] PROT_BASE = 23'h10_0000;
  localparam int unsigned PROT_STEP_SH = 8;
  localparam int unsigned DPS_W = 5;
  // Reset values
  localparam logic [DIV_W-1:0] RST_DIV = 7'h00;
  localparam logic [DPS_W-1:0] RST_DPS = 5'h1F;
  localparam logic [IRQ_W-1:0] RST_IRQ_MASK = 3'h0;
  localparam logic [15:0] RST_WORD = 16'h0000;

  // Parameters handed to the program/erase engine at launch
  typedef struct packed {
    logic [7:0] code;
    logic [22:0] addr;
    logic [3:0][15:0] data;
  } fcoi_cmd_s;

  // Result word written back by the engine
  typedef struct packed {
    logic we;
    logic [IDX_W-1:0] idx;
    logic [15:0] dat;
  } fcoi_res_s;
endpackage : fcoi_pkg

// file: core/fcoi_top.sv
// Flash command object interface with Wishbone register slave.
//
// The implementer's own choices: the register addresses and register access over Wishbone.
`timescale 1ns/1ps
`default_nettype none
module fcoi_top (
  input wire logic core_clk_i,
  input wire logic arst_n_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic irq_o,
  output logic cmd_launch_o,
  output fcoi_pkg::fcoi_cmd_s cmd_o,
  output logic [fcoi_pkg::DIV_W-1:0] fdiv_o,
  output logic [22:0] prot_end_o,
  input wire logic eng_done_i,
  input wire logic eng_pviol_i,
  input wire fcoi_pkg::fcoi_res_s eng_res_i
);

  // Upper end of the protected range for a size code
  function automatic logic [22:0] prot_end_of(input logic [4:0] dflash_protect_size);
    logic [22:0] span;
    span = (23'(dflash_protect_size) + 23'h000001) << fcoi_pkg::PROT_STEP_SH;
    prot_end_of = fcoi_pkg::PROT_BASE + span - 23'h000001;
  endfunction

  // Byte-lane merge of a 16-bit word
  function automatic logic [15:0] merge16(input logic [15:0] old,
                                          input logic [15:0] nw,
                                          input logic [1:0] sel);
    merge16[7:0] = sel[0] ? nw[7:0] : old[7:0];
    merge16[15:8] = sel[1] ? nw[15:8] : old[15:8];
  endfunction

  logic [15:0] cob_ff [fcoi_pkg::COB_WORDS];
  logic [15:0] nxt_cob [fcoi_pkg::COB_WORDS];
  logic [2:0] idx_ff, nxt_idx;
  logic command_complete_flag_ff, nxt_command_complete_flag;
  logic access_error_flag_ff, nxt_access_error_flag;
  logic pviol_ff, nxt_pviol;
  logic [fcoi_pkg::DIV_W-1:0] div_ff, nxt_div;
  logic div_ld_ff, nxt_div_ld;
  logic [4:0] dps_ff, nxt_dps;
  logic [22:0] pend_ff, nxt_pend;
  logic [2:0] irq_st_ff, nxt_irq_st;
  logic [2:0] irq_mk_ff, nxt_irq_mk;
  logic ack_ff, nxt_ack;
  logic [31:0] rdat_ff, nxt_rdat;
  logic launch_ff, nxt_launch;
  fcoi_pkg::fcoi_cmd_s cmd_ff, nxt_cmd;
  logic req, wr, rd, idx_valid, sw_cob_we, launch_try, launch_ok;
  logic [15:0] cur_word;

  // Bus request decode, one access per ack
  assign req = wb_cyc_i && wb_stb_i && !ack_ff;
  assign wr = req && wb_we_i;
  assign rd = req && !wb_we_i;
  assign idx_valid = idx_ff < 3'(fcoi_pkg::COB_WORDS);
  assign cur_word = idx_valid ? cob_ff[idx_ff] : 16'h0000;
  assign sw_cob_we = wr && wb_adr_i == fcoi_pkg::OFS_WORD && command_complete_flag_ff &&
                     idx_valid && |wb_sel_i[1:0];
  assign launch_try = wr && wb_adr_i == fcoi_pkg::OFS_STATUS && wb_sel_i[0] &&
                      wb_dat_i[fcoi_pkg::COMMAND_COMPLETE_FLAG_POS] && command_complete_flag_ff;
  assign launch_ok = launch_try && div_ld_ff && !access_error_flag_ff && !pviol_ff;

  // Parameter words: software writes, engine results
  always_comb begin
    for (int i = 0; i < fcoi_pkg::COB_WORDS; i++) begin
      nxt_cob[i] = cob_ff[i];
      if (sw_cob_we && idx_ff == 3'(i)) begin
        nxt_cob[i] = merge16(cob_ff[i], wb_dat_i[15:0], wb_sel_i[1:0]);
      end
      if (!command_complete_flag_ff && eng_res_i.we && eng_res_i.idx == 3'(i)) begin
        nxt_cob[i] = eng_res_i.dat;
      end
    end
  end

  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      for (int i = 0; i < fcoi_pkg::COB_WORDS; i++) begin
        cob_ff[i] <= fcoi_pkg::RST_WORD;
      end
    end else begin
      cob_ff <= nxt_cob;
    end
  end

  // Control and status next state
  always_comb begin
    nxt_idx = idx_ff;
    nxt_command_complete_flag = command_complete_flag_ff;
    nxt_access_error_flag = access_error_flag_ff;
    nxt_pviol = pviol_ff;
    nxt_div = div_ff;
    nxt_div_ld = div_ld_ff;
    nxt_dps = dps_ff;
    nxt_irq_mk = irq_mk_ff;
    nxt_irq_st = irq_st_ff;
    if (wr && wb_adr_i == fcoi_pkg::OFS_INDEX && wb_sel_i[0]) begin
      nxt_idx = wb_dat_i[2:0];
    end
    // Error flags clear on write of one
    if (wr && wb_adr_i == fcoi_pkg::OFS_STATUS && wb_sel_i[0]) begin
      if (wb_dat_i[fcoi_pkg::ACCESS_ERROR_FLAG_POS]) begin
        nxt_access_error_flag = 1'b0;
      end
      if (wb_dat_i[fcoi_pkg::PROTECTION_VIOLATION_FLAG_POS]) begin
        nxt_pviol = 1'b0;
      end
    end
    if (wr && wb_adr_i == fcoi_pkg::OFS_CLKDIV && wb_sel_i[0] && command_complete_flag_ff) begin
      nxt_div = wb_dat_i[fcoi_pkg::DIV_W-1:0];
      nxt_div_ld = 1'b1;
    end
    if (wr && wb_adr_i == fcoi_pkg::OFS_PROT_SIZE && wb_sel_i[0]) begin
      nxt_dps = wb_dat_i[4:0];
    end
    if (wr && wb_adr_i == fcoi_pkg::OFS_IRQ_MASK && wb_sel_i[0]) begin
      nxt_irq_mk = wb_dat_i[2:0];
    end
    if (launch_ok) begin
      nxt_command_complete_flag = 1'b0;
    end
    if (!command_complete_flag_ff && eng_done_i) begin
      nxt_command_complete_flag = 1'b1;
    end
    if (launch_try && !div_ld_ff) begin
      nxt_access_error_flag = 1'b1;
    end
    if (eng_pviol_i) begin
      nxt_pviol = 1'b1;
    end
    // Read clears interrupt status, new events win
    if (rd && wb_adr_i == fcoi_pkg::OFS_IRQ_STAT) begin
      nxt_irq_st = 3'h0;
    end
    if (!command_complete_flag_ff && eng_done_i) begin
      nxt_irq_st[fcoi_pkg::IRQ_DONE_POS] = 1'b1;
    end
    if (launch_try && !div_ld_ff) begin
      nxt_irq_st[fcoi_pkg::IRQ_ACCESS_ERROR_FLAG_POS] = 1'b1;
    end
    if (eng_pviol_i) begin
      nxt_irq_st[fcoi_pkg::IRQ_PVIOL_POS] = 1'b1;
    end
  end

  // Control and status registers
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      idx_ff <= 3'h0;
      command_complete_flag_ff <= 1'b1;
      access_error_flag_ff <= 1'b0;
      pviol_ff <= 1'b0;
      div_ff <= fcoi_pkg::RST_DIV;
      div_ld_ff <= 1'b0;
      dps_ff <= fcoi_pkg::RST_DPS;
      irq_mk_ff <= fcoi_pkg::RST_IRQ_MASK;
      irq_st_ff <= 3'h0;
    end else begin
      idx_ff <= nxt_idx;
      command_complete_flag_ff <= nxt_command_complete_flag;
      access_error_flag_ff <= nxt_access_error_flag;
      pviol_ff <= nxt_pviol;
      div_ff <= nxt_div;
      div_ld_ff <= nxt_div_ld;
      dps_ff <= nxt_dps;
      irq_mk_ff <= nxt_irq_mk;
      irq_st_ff <= nxt_irq_st;
    end
  end

  // Bus answer, launch capture and protection decode
  always_comb begin
    nxt_ack = req;
    nxt_launch = launch_ok;
    nxt_cmd = cmd_ff;
    nxt_rdat = 32'h0000_0000;
    nxt_pend = prot_end_of(dps_ff);
    if (launch_ok) begin
      nxt_cmd.code = cob_ff[0][15:8];
      nxt_cmd.addr = {cob_ff[0][6:0], cob_ff[1]};
      nxt_cmd.data = {cob_ff[5], cob_ff[4], cob_ff[3], cob_ff[2]};
    end
    if (rd) begin
      case (wb_adr_i)
        fcoi_pkg::OFS_INDEX: nxt_rdat = {29'h0, idx_ff};
        fcoi_pkg::OFS_WORD: nxt_rdat = {16'h0000, cur_word};
        fcoi_pkg::OFS_STATUS: nxt_rdat = {24'h0, command_complete_flag_ff, 1'b0, access_error_flag_ff,
                                          pviol_ff, 4'h0};
        fcoi_pkg::OFS_CLKDIV: nxt_rdat = {24'h0, div_ld_ff, div_ff};
        fcoi_pkg::OFS_PROT_SIZE: nxt_rdat = {27'h0, dps_ff};
        fcoi_pkg::OFS_PROT_END: nxt_rdat = {9'h0, pend_ff};
        fcoi_pkg::OFS_RSV_ZERO: nxt_rdat = 32'h0000_0000;
        fcoi_pkg::OFS_IRQ_STAT: nxt_rdat = {29'h0, irq_st_ff};
        fcoi_pkg::OFS_IRQ_MASK: nxt_rdat = {29'h0, irq_mk_ff};
        default: nxt_rdat = 32'h0000_0000;
      endcase
    end
  end

  // Bus answer and launch registers
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ack_ff <= 1'b0;
      launch_ff <= 1'b0;
      cmd_ff <= '0;
      rdat_ff <= 32'h0000_0000;
      pend_ff <= 23'h000000;
    end else begin
      ack_ff <= nxt_ack;
      launch_ff <= nxt_launch;
      cmd_ff <= nxt_cmd;
      rdat_ff <= nxt_rdat;
      pend_ff <= nxt_pend;
    end
  end

  // Outputs
  assign wb_ack_o = ack_ff;
  assign wb_dat_o = rdat_ff;
  assign cmd_launch_o = launch_ff;
  assign cmd_o = cmd_ff;
  assign fdiv_o = div_ff;
  assign prot_end_o = pend_ff;
  assign irq_o = |(irq_st_ff & irq_mk_ff);

  // Assertions
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!arst_n_i);
  logic [15:0] w0_q;
  logic [15:0] w5_q;
  assign w0_q = cob_ff[0];
  assign w5_q = cob_ff[5];

  chk_lock_words: assert property (!command_complete_flag_ff |-> !sw_cob_we)
    else $error("parameter word written while busy");
  chk_busy_ignore: assert property (!command_complete_flag_ff && !eng_res_i.we |=>
    $stable(w0_q) && $stable(w5_q))
    else $error("parameter word changed while busy");
  chk_launch_clears: assert property (launch_ok |=>
    !command_complete_flag_ff && cmd_launch_o ##1 !cmd_launch_o)
    else $error("launch did not clear flag");
  chk_flag_holds: assert property (!command_complete_flag_ff && !eng_done_i |=> !command_complete_flag_ff)
    else $error("complete flag rose without engine");
  chk_done_sets: assert property (!command_complete_flag_ff && eng_done_i |=>
    command_complete_flag_ff && irq_st_ff[fcoi_pkg::IRQ_DONE_POS])
    else $error("completion not recorded");
  chk_unimpl_zero: assert property (rd && wb_adr_i == fcoi_pkg::OFS_WORD &&
    !idx_valid |=> wb_dat_o == 32'h0000_0000)
    else $error("unimplemented word read nonzero");
  chk_rsv_zero: assert property (rd && wb_adr_i == fcoi_pkg::OFS_RSV_ZERO
    |=> wb_dat_o == 32'h0000_0000 && wb_ack_o)
    else $error("reserved register read nonzero");
  chk_prot_span: assert property ($past(arst_n_i) |->
    32'(prot_end_o) - 32'h0010_0000 + 1 == (32'($past(dps_ff)) + 1) * 256)
    else $error("protected span wrong");
  chk_div_access_error_flag: assert property (launch_try && !div_ld_ff |=>
    access_error_flag_ff && command_complete_flag_ff && !cmd_launch_o)
    else $error("launch without divider not refused");
  chk_cmd_fields: assert property (launch_ok |=>
    cmd_o.code == $past(w0_q[15:8]) && cmd_o.addr[22:16] == $past(w0_q[6:0]))
    else $error("command code or address wrong");
  chk_word_write: assert property (sw_cob_we && idx_ff == 3'h5 &&
    wb_sel_i[1:0] == 2'b01 |=> w5_q[15:8] == $past(w5_q[15:8]))
    else $error("low byte write touched high byte");
  chk_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");

  cov_launch: cover property (launch_ok ##[1:50] eng_done_i);
  cov_access_error_flag: cover property (launch_try && !div_ld_ff);
  cov_byte_wr: cover property (sw_cob_we && wb_sel_i[1:0] == 2'b10);
  cov_irq: cover property (irq_o);

endmodule // fcoi_top
`default_nettype wire

// file: verification/fcoi_top_tb.sv
// Self-checking bench for the flash command object interface.
`timescale 1ns/1ps
`default_nettype none
module fcoi_top_tb;
  logic core_clk, arst_n, cyc, stb, we, eng_done, eng_pviol;
  logic ack, irq, launch;
  logic [7:0] adr, b;
  logic [3:0] sel;
  logic [31:0] dat_i, dat_o, seed;
  logic [6:0] fdiv;
  logic [22:0] prot_end;
  logic [15:0] w[8];
  fcoi_pkg::fcoi_cmd_s cmd;
  fcoi_pkg::fcoi_res_s res;
  logic [31:0] rd_q[$];
  fcoi_pkg::fcoi_cmd_s cmd_q[$];
  int n_errors, cmp_count, i;

  fcoi_top uut (
    .core_clk_i(core_clk), .arst_n_i(arst_n), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
    .wb_dat_i(dat_i), .wb_dat_o(dat_o), .wb_ack_o(ack), .irq_o(irq),
    .cmd_launch_o(launch), .cmd_o(cmd), .fdiv_o(fdiv),
    .prot_end_o(prot_end), .eng_done_i(eng_done),
    .eng_pviol_i(eng_pviol), .eng_res_i(res)
  );

  // Clock at 20 MHz
  always #25 core_clk = ~core_clk;

  function automatic logic [31:0] xs(input logic [31:0] x);
    logic [31:0] y;
    y = x ^ (x << 13);
    y = y ^ (y >> 17);
    return y ^ (y << 5);
  endfunction

  task automatic chk(input logic [127:0] seen, input logic [127:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic results;
    $display("Counts: %0d compares, %0d mismatches", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // One classic Wishbone cycle, held until ack is sampled high
  task automatic bus(input logic wr_en, input logic [7:0] a,
                     input logic [3:0] s, input logic [31:0] d);
    int k;
    @(posedge core_clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= wr_en;
    adr <= a;
    sel <= s;
    dat_i <= d;
    k = 0;
    do begin
      @(posedge core_clk);
      k++;
    end while (ack !== 1'b1 && k < 50);
    if (k >= 50) begin
      n_errors++;
      $display("[ERR] %0t no bus answer", $time);
    end
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [3:0] s,
                    input logic [31:0] d);
    bus(1'b1, a, s, d);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    rd_q.push_back(e);
    bus(1'b0, a, 4'hF, 32'h0000_0000);
  endtask

  // Engine writes a result, then reports completion
  task automatic engine(input logic [2:0] idx, input logic [15:0] d);
    @(posedge core_clk);
    res <= '{we: 1'b1, idx: idx, dat: d};
    @(posedge core_clk);
    res <= '0;
    eng_done <= 1'b1;
    @(posedge core_clk);
    eng_done <= 1'b0;
  endtask

  // Read answers and launches checked against the oldest note
  always @(posedge core_clk) begin
    if (ack === 1'b1 && cyc === 1'b1 && we === 1'b0)
      chk(dat_o, rd_q.size() ? rd_q.pop_front() : 32'hDEAD_BEEF);
    if (launch === 1'b1) begin
      if (cmd_q.size() == 0) begin
        n_errors++;
        $display("[ERR] %0t unexpected launch", $time);
      end else chk(cmd, cmd_q.pop_front());
    end
  end

  // Watchdog well beyond the expected run length
  initial begin
    #1_000_000;
    n_errors++;
    $display("[ERR] %0t watchdog expired", $time);
    results;
  end

  initial begin
    core_clk = 1'b0; arst_n = 1'b0; cyc = 1'b0; stb = 1'b0; we = 1'b0;
    adr = 8'h00; sel = 4'h0; dat_i = 32'h0; eng_done = 1'b0;
    eng_pviol = 1'b0; res = '0; seed = 32'hFC18_317E;
    n_errors = 0; cmp_count = 0;
    repeat (12) @(posedge core_clk);
    arst_n <= 1'b1;
    rd(fcoi_pkg::OFS_STATUS, 32'h80);
    wr(fcoi_pkg::OFS_RSV_ZERO, 4'hF, 32'hFFFF_FFFF);
    rd(fcoi_pkg::OFS_RSV_ZERO, 32'h0);
    $display("Test reset and reserved done");
    for (i = 0; i < 32; i++) begin
      wr(fcoi_pkg::OFS_PROT_SIZE, 4'h1, 32'(i));
      rd(fcoi_pkg::OFS_PROT_END, 32'h10_0000 + (i + 1) * 256 - 1);
      chk(prot_end, 32'h10_0000 + (i + 1) * 256 - 1);
    end
    $display("Test protect decode done");
    // word and byte access at every index
    for (i = 0; i < 8; i++) begin
      seed = xs(seed);
      b = seed[23:16] & 8'h7F;
      w[i] = seed[15:0] & ((i == 0) ? 16'hFF7F : 16'hFFFF);
      wr(fcoi_pkg::OFS_INDEX, 4'h1, 32'(i));
      wr(fcoi_pkg::OFS_WORD, 4'h3, {16'h0, w[i]});
      if (i % 2) w[i][7:0] = b;
      else w[i][15:8] = b;
      wr(fcoi_pkg::OFS_WORD, (i % 2) ? 4'h1 : 4'h2, {16'h0, b, b});
      if (i > 5) w[i] = 16'h0000;
      rd(fcoi_pkg::OFS_WORD, {16'h0, w[i]});
    end
    $display("Test object words done");
    wr(fcoi_pkg::OFS_STATUS, 4'h1, 32'h80);
    rd(fcoi_pkg::OFS_STATUS, 32'hA0);
    chk(irq, 1'b0);
    rd(fcoi_pkg::OFS_IRQ_STAT, 32'h2);
    rd(fcoi_pkg::OFS_IRQ_STAT, 32'h0);
    wr(fcoi_pkg::OFS_STATUS, 4'h1, 32'h20);
    wr(fcoi_pkg::OFS_CLKDIV, 4'h1, 32'h05);
    rd(fcoi_pkg::OFS_CLKDIV, 32'h85);
    chk(fdiv, 7'h05);
    wr(fcoi_pkg::OFS_IRQ_MASK, 4'h1, 32'h7);
    $display("Test divider error done");
    wr(fcoi_pkg::OFS_INDEX, 4'h1, 32'h2);
    cmd_q.push_back('{code: w[0][15:8], addr: {w[0][6:0], w[1]},
                      data: {w[5], w[4], w[3], w[2]}});
    wr(fcoi_pkg::OFS_STATUS, 4'h1, 32'h80);
    rd(fcoi_pkg::OFS_STATUS, 32'h00);
    wr(fcoi_pkg::OFS_WORD, 4'h3, {16'h0, ~w[2]});
    wr(fcoi_pkg::OFS_STATUS, 4'h1, 32'h80);
    engine(3'd3, 16'hC3E1);
    w[3] = 16'hC3E1;
    rd(fcoi_pkg::OFS_STATUS, 32'h80);
    chk(irq, 1'b1);
    rd(fcoi_pkg::OFS_IRQ_STAT, 32'h1);
    rd(fcoi_pkg::OFS_WORD, {16'h0, w[2]});
    chk(irq, 1'b0);
    wr(fcoi_pkg::OFS_INDEX, 4'h1, 32'h3);
    rd(fcoi_pkg::OFS_INDEX, 32'h3);
    rd(fcoi_pkg::OFS_WORD, {16'h0, w[3]});
    $display("Test launch done");
    // pending violation holds off a launch
    @(posedge core_clk);
    eng_pviol <= 1'b1;
    @(posedge core_clk);
    eng_pviol <= 1'b0;
    wr(fcoi_pkg::OFS_STATUS, 4'h1, 32'h80);
    rd(fcoi_pkg::OFS_STATUS, 32'h90);
    rd(fcoi_pkg::OFS_IRQ_STAT, 32'h4);
    wr(fcoi_pkg::OFS_STATUS, 4'h1, 32'h10);
    rd(fcoi_pkg::OFS_STATUS, 32'h80);
    $display("Test violation done");
    repeat (4) @(posedge core_clk);
    chk(rd_q.size() + cmd_q.size(), 0);
    results;
  end
endmodule // fcoi_top_tb
`default_nettype wire
